// File: rtl/i2c_status_defs.svh
// Register offsets, field positions, reset values and timing constants.
`ifndef I2C_STATUS_DEFS_SVH
`define I2C_STATUS_DEFS_SVH

// ==========================================================================
// Register byte offsets on the APB port.
`define CMD_OFS            12'h000
`define BUS_STATUS_OFS     12'h004
`define INT_EN_SET_OFS     12'h008
`define INT_EN_CLR_OFS     12'h00c
`define LIMIT_OFS          12'h010

// ==========================================================================
// Field positions shared by the status and interrupt enable registers.
`define MST_PEND_BIT       0
`define MST_STATE_LSB      1
`define MST_STATE_MSB      3
`define SLV_PEND_BIT       8
`define SLV_STATE_LSB      9
`define SLV_STATE_MSB      10
`define SLV_SEL_BIT        14
`define SLV_DESEL_BIT      15
`define EVT_TO_BIT         24
`define SCL_TO_BIT         25

// Interrupt-capable status bits; everything else in the enable reads zero.
`define INT_EN_MASK        32'h0300_8101

// ==========================================================================
// Command register bit positions (write-one pulses).
`define CMD_MST_CONT_BIT   0
`define CMD_MST_START_BIT  1
`define CMD_MST_STOP_BIT   2
`define CMD_SLV_CONT_BIT   8
`define CMD_SLV_REFUSE_BIT 9

// ==========================================================================
// Reset values and time-out tick.
`define LIMIT_RESET        16'hffff
`define MST_PEND_RESET     1'b1
`define TICK_DIV_LAST      4'hf

// Master and slave state codes as seen by software.
`define MST_CODE_IDLE      3'h0
`define MST_CODE_RX        3'h1
`define MST_CODE_TX        3'h2
`define MST_CODE_ADDR_NAK  3'h3
`define MST_CODE_DATA_NAK  3'h4
`define SLV_CODE_ADDR      2'h0
`define SLV_CODE_RX        2'h1
`define SLV_CODE_TX        2'h2

`endif

// File: rtl/i2c_status_pkg.sv
// Types shared by the I2C state and time-out status block.
`default_nettype none

package i2c_status_pkg;

	// ======================================================================
	// APB request from the bus master.
	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} apb_req_type;

	// APB answer from this slave.
	typedef struct packed {
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} apb_rsp_type;

	// ======================================================================
	// One-cycle event pulses from the master shifter.
	typedef struct packed {
		logic addr_ack_rd;
		logic addr_ack_wr;
		logic addr_nack;
		logic data_nack;
		logic byte_rx;
		logic byte_tx_ack;
		logic stopped;
	} mst_event_type;

	// One-cycle event pulses from the slave shifter.
	typedef struct packed {
		logic addr_match;
		logic byte_rx;
		logic tx_ready;
		logic master_nack;
		logic stopped;
	} slv_event_type;

	// One-cycle command pulses to the shifters.
	typedef struct packed {
		logic mst_continue;
		logic mst_start;
		logic mst_stop;
		logic slv_proceed;
		logic slv_refuse;
	} cmd_type;

	// ======================================================================
	// Master role state, Gray coded along idle, tx, rx.
	typedef enum logic [2:0] {
		MST_IDLE     = 3'b000,
		MST_TX       = 3'b001,
		MST_RX       = 3'b011,
		MST_ADDR_NAK = 3'b010,
		MST_DATA_NAK = 3'b110
	} mst_state_type;

	// Slave role state, Gray coded along address, rx, tx.
	typedef enum logic [1:0] {
		SLV_ADDR = 2'b00,
		SLV_RX   = 2'b01,
		SLV_TX   = 2'b11
	} slv_state_type;

endpackage

`default_nettype wire

// File: rtl/i2c_status.sv
// I2C role state reporting, bus time-out detection and status registers.
//
// Functional notes
// - Event gap beyond limit sets event time-out.
// - Start, stop and clock edges restart gap.
// - No event time-out while bus idle.
// - Clock low beyond limit sets clock time-out.
// - Time-out flags reset zero, write-one clears.
// - Master idle reads 0, no DMA.
// - Master receive ready reads 1, DMA.
// - Master transmit ready reads 2, DMA.
// - Address refusal 3, data refusal 4, no DMA.
// - Slave address matched reads 0, no DMA.
// - Slave receive ready reads 1, DMA.
// - Slave transmit reads 2; master refusal deselects.
// - Deselect flag on selected falling, write-one clears.
// - Flags interrupt only when enabled.
`include "i2c_status_defs.svh"
`default_nettype none

module i2c_status (
	// Clock and reset.
	input  wire logic                        clk,
	input  wire logic                        rst_n,
	// APB register port.
	input  wire i2c_status_pkg::apb_req_type apb_req,
	output logic                             pready,
	output logic                             pslverr,
	output logic [31:0]                      prdata,
	// I2C bus lines, observed only.
	input  wire logic                        scl_in,
	input  wire logic                        sda_in,
	// Shifter events and commands.
	input  wire i2c_status_pkg::mst_event_type mst_event,
	input  wire i2c_status_pkg::slv_event_type slv_event,
	output i2c_status_pkg::cmd_type          cmd,
	// DMA permission and interrupt.
	output logic                             mst_dma_ok,
	output logic                             slv_dma_ok,
	output logic                             irq
);
	import i2c_status_pkg::*;

	// ======================================================================
	// Bus line synchronisers. Only the second stage is read by logic.
	logic [1:0] scl_sync_ff;
	logic [1:0] sda_sync_ff;
	logic       scl_prev_ff;
	logic       sda_prev_ff;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			scl_sync_ff <= 2'h3;
			sda_sync_ff <= 2'h3;
			scl_prev_ff <= 1'b1;
			sda_prev_ff <= 1'b1;
		end else begin
			scl_sync_ff <= {scl_sync_ff[0], scl_in};
			sda_sync_ff <= {sda_sync_ff[0], sda_in};
			scl_prev_ff <= scl_sync_ff[1];
			sda_prev_ff <= sda_sync_ff[1];
		end
	end

	logic scl_now;
	logic sda_now;
	logic scl_edge;
	logic start_seen;
	logic stop_seen;
	logic bus_event;

	// Start and stop are data edges while the clock line stays high.
	assign scl_now    = scl_sync_ff[1];
	assign sda_now    = sda_sync_ff[1];
	assign scl_edge   = scl_now ^ scl_prev_ff;
	assign start_seen = scl_now && scl_prev_ff && sda_prev_ff && !sda_now;
	assign stop_seen  = scl_now && scl_prev_ff && !sda_prev_ff && sda_now;
	assign bus_event  = scl_edge || start_seen || stop_seen;

	// Busy from a start until the next stop.
	logic bus_busy_ff;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bus_busy_ff <= 1'b0;
		end else if (start_seen) begin
			bus_busy_ff <= 1'b1;
		end else if (stop_seen) begin
			bus_busy_ff <= 1'b0;
		end
	end

	// ======================================================================
	// Time-out tick: one enable pulse every sixteen clocks keeps the
	// counters at sixteen bits while still covering long stalls.
	logic [3:0] tick_div_ff;
	logic       tick;

	assign tick = (tick_div_ff == `TICK_DIV_LAST);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tick_div_ff <= 4'h0;
		end else begin
			tick_div_ff <= tick_div_ff + 4'h1;
		end
	end

	// ======================================================================
	// APB decode. Zero wait states; unmapped addresses answer an error.
	logic        wr_en;
	logic        rd_en;
	logic        addr_ok;
	logic [11:0] addr;
	logic [31:0] wdata;

	assign addr    = apb_req.paddr;
	assign wdata   = apb_req.pwdata;
	assign addr_ok = (addr == `CMD_OFS) || (addr == `BUS_STATUS_OFS) ||
	                 (addr == `INT_EN_SET_OFS) ||
	                 (addr == `INT_EN_CLR_OFS) || (addr == `LIMIT_OFS);
	assign wr_en   = apb_req.psel && apb_req.penable && apb_req.pwrite;
	assign rd_en   = apb_req.psel && apb_req.penable && !apb_req.pwrite;
	assign pready  = 1'b1;
	assign pslverr = apb_req.psel && apb_req.penable && !addr_ok;

	logic stat_wr;
	logic cmd_wr;

	assign stat_wr = wr_en && (addr == `BUS_STATUS_OFS);
	assign cmd_wr  = wr_en && (addr == `CMD_OFS);

	// ======================================================================
	// Time-out limit, counted in ticks.
	logic [15:0] limit_ff;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			limit_ff <= `LIMIT_RESET;
		end else if (wr_en && (addr == `LIMIT_OFS)) begin
			limit_ff <= wdata[15:0];
		end
	end

	// Gap since the last bus event; cleared while idle so that a stale
	// count cannot fire on the first start.
	logic [15:0] evt_cnt_ff;
	logic [15:0] low_cnt_ff;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			evt_cnt_ff <= 16'h0000;
		end else if (bus_event || !bus_busy_ff) begin
			evt_cnt_ff <= 16'h0000;
		end else if (tick && (evt_cnt_ff != 16'hffff)) begin
			evt_cnt_ff <= evt_cnt_ff + 16'h0001;
		end
	end

	// Clock-low time, restarted whenever the clock line is high.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			low_cnt_ff <= 16'h0000;
		end else if (scl_now) begin
			low_cnt_ff <= 16'h0000;
		end else if (tick && (low_cnt_ff != 16'hffff)) begin
			low_cnt_ff <= low_cnt_ff + 16'h0001;
		end
	end

	logic evt_over;
	logic low_over;

	assign evt_over = bus_busy_ff && (evt_cnt_ff > limit_ff);
	assign low_over = !scl_now && (low_cnt_ff > limit_ff);

	// Sticky time-out flags; a new time-out beats a clear in the
	// same cycle.
	logic evt_to_ff;
	logic scl_to_ff;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			evt_to_ff <= 1'b0;
			scl_to_ff <= 1'b0;
		end else begin
			evt_to_ff <= evt_over ||
			             (evt_to_ff && !(stat_wr && wdata[`EVT_TO_BIT]));
			scl_to_ff <= low_over ||
			             (scl_to_ff && !(stat_wr && wdata[`SCL_TO_BIT]));
		end
	end

	// ======================================================================
	// Command pulses, one cycle after the write is taken.
	cmd_type cmd_ff;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cmd_ff <= '0;
		end else begin
			cmd_ff.mst_continue <= cmd_wr && wdata[`CMD_MST_CONT_BIT];
			cmd_ff.mst_start    <= cmd_wr && wdata[`CMD_MST_START_BIT];
			cmd_ff.mst_stop     <= cmd_wr && wdata[`CMD_MST_STOP_BIT];
			cmd_ff.slv_proceed  <= cmd_wr && wdata[`CMD_SLV_CONT_BIT];
			cmd_ff.slv_refuse   <= cmd_wr && wdata[`CMD_SLV_REFUSE_BIT];
		end
	end

	assign cmd = cmd_ff;

	logic mst_cmd_any;
	logic slv_cmd_any;

	assign mst_cmd_any = cmd_wr && (wdata[`CMD_MST_CONT_BIT] ||
	                     wdata[`CMD_MST_START_BIT] || wdata[`CMD_MST_STOP_BIT]);
	assign slv_cmd_any = cmd_wr && (wdata[`CMD_SLV_CONT_BIT] ||
	                     wdata[`CMD_SLV_REFUSE_BIT]);

	// ======================================================================
	// Master role state, following the shifter's reports.
	mst_state_type mst_state_ff;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mst_state_ff <= MST_IDLE;
		end else begin
			case (1'b1)
				mst_event.stopped:     mst_state_ff <= MST_IDLE;
				mst_event.addr_nack:   mst_state_ff <= MST_ADDR_NAK;
				mst_event.data_nack:   mst_state_ff <= MST_DATA_NAK;
				mst_event.addr_ack_rd: mst_state_ff <= MST_RX;
				mst_event.byte_rx:     mst_state_ff <= MST_RX;
				mst_event.addr_ack_wr: mst_state_ff <= MST_TX;
				mst_event.byte_tx_ack: mst_state_ff <= MST_TX;
				default:               mst_state_ff <= mst_state_ff;
			endcase
		end
	end

	// Pending: the master waits for software. Idle counts as pending, so
	// software masks it when no master work is queued.
	logic mst_pend_ff;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mst_pend_ff <= `MST_PEND_RESET;
		end else if (|mst_event) begin
			mst_pend_ff <= 1'b1;
		end else if (mst_cmd_any) begin
			mst_pend_ff <= 1'b0;
		end
	end

	logic [2:0] mst_code;

	always_comb begin
		mst_code   = `MST_CODE_IDLE;
		mst_dma_ok = 1'b0;
		case (mst_state_ff)
			MST_RX: begin
				mst_code   = `MST_CODE_RX;
				mst_dma_ok = mst_pend_ff;
			end
			MST_TX: begin
				mst_code   = `MST_CODE_TX;
				mst_dma_ok = mst_pend_ff;
			end
			MST_ADDR_NAK: mst_code = `MST_CODE_ADDR_NAK;
			MST_DATA_NAK: mst_code = `MST_CODE_DATA_NAK;
			default:      mst_code = `MST_CODE_IDLE;
		endcase
	end

	// ======================================================================
	// Slave role state and selection.
	slv_state_type slv_state_ff;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			slv_state_ff <= SLV_ADDR;
		end else if (slv_event.addr_match) begin
			slv_state_ff <= SLV_ADDR;
		end else if (slv_event.byte_rx) begin
			slv_state_ff <= SLV_RX;
		end else if (slv_event.tx_ready) begin
			slv_state_ff <= SLV_TX;
		end
	end

	// Selection ends on stop, on a refused address, or when the master
	// refuses a byte that this slave sent.
	logic slv_sel_ff;
	logic slv_drop;

	assign slv_drop = slv_event.stopped ||
	                  (slv_event.master_nack && slv_state_ff == SLV_TX) ||
	                  (cmd_wr && wdata[`CMD_SLV_REFUSE_BIT] &&
	                   slv_state_ff == SLV_ADDR);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			slv_sel_ff <= 1'b0;
		end else if (slv_event.addr_match) begin
			slv_sel_ff <= 1'b1;
		end else if (slv_drop) begin
			slv_sel_ff <= 1'b0;
		end
	end

	// Slave pending: waiting for software while selected.
	logic slv_pend_ff;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			slv_pend_ff <= 1'b0;
		end else if (slv_event.addr_match || slv_event.byte_rx ||
		             slv_event.tx_ready) begin
			slv_pend_ff <= 1'b1;
		end else if (slv_cmd_any || slv_drop) begin
			slv_pend_ff <= 1'b0;
		end
	end

	// Deselect flag: set on the falling selection, the set beating a
	// write-one clear in the same cycle.
	logic slv_sel_prev_ff;
	logic desel_ff;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			slv_sel_prev_ff <= 1'b0;
			desel_ff        <= 1'b0;
		end else begin
			slv_sel_prev_ff <= slv_sel_ff;
			desel_ff        <= (slv_sel_prev_ff && !slv_sel_ff) ||
			                   (desel_ff &&
			                    !(stat_wr && wdata[`SLV_DESEL_BIT]));
		end
	end

	logic [1:0] slv_code;

	always_comb begin
		slv_code   = `SLV_CODE_ADDR;
		slv_dma_ok = 1'b0;
		case (slv_state_ff)
			SLV_RX: begin
				slv_code   = `SLV_CODE_RX;
				slv_dma_ok = slv_pend_ff;
			end
			SLV_TX: begin
				slv_code   = `SLV_CODE_TX;
				slv_dma_ok = slv_pend_ff;
			end
			default: slv_code = `SLV_CODE_ADDR;
		endcase
	end

	// ======================================================================
	// Status word; reserved bits read zero, writes to them are ignored.
	logic [31:0] status;

	always_comb begin
		status                                      = 32'h0000_0000;
		status[`MST_PEND_BIT]                       = mst_pend_ff;
		status[`MST_STATE_MSB:`MST_STATE_LSB]       = mst_code;
		status[`SLV_PEND_BIT]                       = slv_pend_ff;
		status[`SLV_STATE_MSB:`SLV_STATE_LSB]       = slv_code;
		status[`SLV_SEL_BIT]                        = slv_sel_ff;
		status[`SLV_DESEL_BIT]                      = desel_ff;
		status[`EVT_TO_BIT]                         = evt_to_ff;
		status[`SCL_TO_BIT]                         = scl_to_ff;
	end

	// Interrupt enables: set and clear by writing ones.
	logic [31:0] int_en_ff;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			int_en_ff <= 32'h0000_0000;
		end else if (wr_en && (addr == `INT_EN_SET_OFS)) begin
			int_en_ff <= int_en_ff | (wdata & `INT_EN_MASK);
		end else if (wr_en && (addr == `INT_EN_CLR_OFS)) begin
			int_en_ff <= int_en_ff & ~wdata;
		end
	end

	// Level interrupt from any enabled status bit.
	assign irq = |(status & int_en_ff);

	// ======================================================================
	// Read mux from register state.
	always_comb begin
		prdata = 32'h0000_0000;
		if (!rd_en) begin
			prdata = 32'h0000_0000;
		end else if (addr == `BUS_STATUS_OFS) begin
			prdata = status;
		end else if (addr == `INT_EN_SET_OFS) begin
			prdata = int_en_ff;
		end else if (addr == `LIMIT_OFS) begin
			prdata = {16'h0000, limit_ff};
		end
	end

endmodule

`default_nettype wire

// File: tb/i2c_status_asserts.sv
// Concurrent checks on the ports of the I2C status block.
`include "i2c_status_defs.svh"
`default_nettype none

// ==========================================================================
// Checker module.
module i2c_status_asserts (
	// Clock and reset.
	input wire logic                          clk,
	input wire logic                          rst_n,
	// Register port.
	input wire i2c_status_pkg::apb_req_type   apb_req,
	input wire logic [31:0]                   prdata,
	// Shifter side and outputs.
	input wire i2c_status_pkg::mst_event_type mst_event,
	input wire i2c_status_pkg::slv_event_type slv_event,
	input wire i2c_status_pkg::cmd_type       cmd,
	input wire logic                          mst_dma_ok,
	input wire logic                          slv_dma_ok,
	input wire logic                          irq
);
	timeunit 1ns;
	timeprecision 1ps;
	import i2c_status_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	logic acc;
	logic mst_hi;
	// Access phase and the master events that outrank data events.
	assign acc = apb_req.psel && apb_req.penable;
	assign mst_hi = mst_event.stopped | mst_event.addr_nack |
	                mst_event.data_nack;

	property p_mst_idle;
		mst_event.stopped |=> !mst_dma_ok;
	endproperty
	a_mst_idle: assert property (p_mst_idle)
		else $error("DMA allowed in idle");
	property p_mst_rx;
		mst_event.addr_ack_rd && !mst_hi |=> mst_dma_ok;
	endproperty
	a_mst_rx: assert property (p_mst_rx)
		else $error("no DMA in master receive");
	property p_mst_tx;
		mst_event.addr_ack_wr && !mst_hi |=> mst_dma_ok;
	endproperty
	a_mst_tx: assert property (p_mst_tx)
		else $error("no DMA in master transmit");
	property p_mst_nak;
		mst_event.addr_nack || mst_event.data_nack |=> !mst_dma_ok;
	endproperty
	a_mst_nak: assert property (p_mst_nak)
		else $error("DMA allowed after refusal");
	property p_slv_addr;
		slv_event.addr_match |=> !slv_dma_ok;
	endproperty
	a_slv_addr: assert property (p_slv_addr)
		else $error("DMA allowed on address match");
	property p_slv_rx;
		slv_event.byte_rx && !slv_event.addr_match |=> slv_dma_ok;
	endproperty
	a_slv_rx: assert property (p_slv_rx)
		else $error("no DMA in slave receive");
	property p_irq_rd;
		acc && !apb_req.pwrite && apb_req.paddr == `INT_EN_SET_OFS
			&& prdata == 32'h0 |-> !irq;
	endproperty
	a_irq_rd: assert property (p_irq_rd)
		else $error("interrupt with no enable set");
	property p_cmd;
		acc && apb_req.pwrite && apb_req.paddr == `CMD_OFS
			&& apb_req.pwdata[0] |=> cmd.mst_continue ##1 !cmd.mst_continue;
	endproperty
	a_cmd: assert property (p_cmd)
		else $error("continue pulse wrong");
endmodule

bind i2c_status i2c_status_asserts u_chk (
	.clk(clk), .rst_n(rst_n), .apb_req(apb_req), .prdata(prdata),
	.mst_event(mst_event), .slv_event(slv_event), .cmd(cmd),
	.mst_dma_ok(mst_dma_ok), .slv_dma_ok(slv_dma_ok), .irq(irq)
);

`default_nettype wire

// File: tb/i2c_bus_partner.sv
// Behavioural I2C bus party making start, clock edges and stop.
`default_nettype none

// ==========================================================================
// Bus party model.
module i2c_bus_partner (
	// Frame controls from the bench.
	input  wire logic frame,
	input  wire logic clock_run,
	input  wire logic stuck_low,
	// Bus lines, pulled up when released.
	output logic      scl,
	output logic      sda
);
	timeunit 1ns;
	timeprecision 1ps;
	logic scl_drv = 1'b1;
	logic sda_drv = 1'b1;
	// Wired with a party that may hold the clock low; released reads high.
	assign scl = scl_drv && !stuck_low;
	assign sda = sda_drv;
	// Start: data falls while the clock is high.
	always @(posedge frame) begin
		#37 sda_drv = 1'b0;
		#80 scl_drv = 1'b0;
	end
	// Stop: data rises while the clock is high.
	always @(negedge frame) begin
		scl_drv = 1'b0;
		#20 sda_drv = 1'b0;
		#40 scl_drv = 1'b1;
		#40 sda_drv = 1'b1;
	end
	// Clock at 160 ns; data moves in the low phase so no false start occurs.
	always begin
		if (frame && clock_run) begin
			scl_drv = 1'b0;
			#20 sda_drv = !sda_drv;
			#60 scl_drv = 1'b1;
			#80;
		end else begin
			#80;
		end
	end
endmodule

`default_nettype wire

// File: tb/i2c_status_bench.sv
// Self-checking bench for the I2C state and time-out status block.
`include "i2c_status_defs.svh"
`default_nettype none

// ==========================================================================
// Bench top.
module i2c_status_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import i2c_status_pkg::*;
	logic          clk = 1'b0;
	logic          rst_n = 1'b0;
	apb_req_type   apb_req = '0;
	mst_event_type mst_event = '0;
	slv_event_type slv_event = '0;
	logic          frame = 1'b0;
	logic          clock_run = 1'b0;
	logic          stuck_low = 1'b0;
	logic          pready, pslverr, irq, mst_dma_ok, slv_dma_ok, scl, sda;
	logic [31:0]   prdata, q;
	logic          err;
	cmd_type       cmd;
	int            n_errors = 0;
	int            tests_run = 0;
	int            n;
	mst_event_type m_ev [5] = '{7'h40, 7'h20, 7'h10, 7'h08, 7'h01};
	logic [2:0]    m_code [5] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h0};
	logic          m_dma [5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0};

	// 125 MHz clock.
	always #4 clk = !clk;

	i2c_status i_dut (
		.clk(clk), .rst_n(rst_n), .apb_req(apb_req), .pready(pready),
		.pslverr(pslverr), .prdata(prdata), .scl_in(scl), .sda_in(sda),
		.mst_event(mst_event), .slv_event(slv_event), .cmd(cmd),
		.mst_dma_ok(mst_dma_ok), .slv_dma_ok(slv_dma_ok), .irq(irq)
	);
	i2c_bus_partner i_bus (
		.frame(frame), .clock_run(clock_run), .stuck_low(stuck_low),
		.scl(scl), .sda(sda)
	);

	// ======================================================================
	// Verdict, comparison and bus tasks.
	task automatic give_verdict;
		if (n_errors == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] got, exp);
		tests_run++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// Read data and the error flag are taken at the edge that samples pready.
	task automatic apb(input logic wr, input logic [11:0] a,
			input logic [31:0] d);
		logic rdy;
		rdy = 1'b0;
		n = 0;
		@(posedge clk);
		apb_req <= '{1'b1, 1'b0, wr, a, d};
		@(posedge clk);
		apb_req.penable <= 1'b1;
		while (!rdy && n < 20) begin
			@(posedge clk);
			rdy = (pready === 1'b1);
			q = prdata;
			err = pslverr;
			n++;
		end
		apb_req <= '0;
		if (!rdy) begin
			n_errors++;
			give_verdict();
		end
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] m, e,
			input string nm);
		apb(1'b0, a, 32'h0);
		chk(nm, q & m, e);
	endtask
	task automatic pulse(input mst_event_type me, input slv_event_type se);
		@(posedge clk);
		mst_event <= me;
		slv_event <= se;
		@(posedge clk);
		mst_event <= '0;
		slv_event <= '0;
		@(negedge clk);
	endtask
	task automatic chk_irq(input logic e, input string nm);
		@(negedge clk);
		chk(nm, {31'h0, irq}, {31'h0, e});
	endtask

	// ======================================================================
	// Main sequence.
	initial begin
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		rd(`BUS_STATUS_OFS, 32'hffff_ffff, 32'h1, "status");
		rd(`INT_EN_SET_OFS, 32'hffff_ffff, 32'h0, "enable");
		rd(`LIMIT_OFS, 32'hffff_ffff, 32'hffff, "limit");
		rd(12'h020, 32'hffff_ffff, 32'h0, "unmapped");
		chk("unmapped error", {31'h0, err}, 32'h1);
		// Every master code in turn, with its DMA permission.
		for (int i = 0; i < 5; i++) begin
			pulse(m_ev[i], '0);
			chk("mst dma", {31'h0, mst_dma_ok}, {31'h0, m_dma[i]});
			rd(`BUS_STATUS_OFS, 32'hf, {28'h0, m_code[i], 1'b1}, "mst");
		end
		apb(1'b1, `CMD_OFS, 32'h3);
		@(negedge clk);
		chk("mst cmd", {27'h0, cmd}, 32'h18);
		rd(`BUS_STATUS_OFS, 32'hf, 32'h0, "mst serviced");
		// Slave codes, then deselect by a master refusal while sending.
		pulse('0, 5'h10);
		chk("slv dma addr", {31'h0, slv_dma_ok}, 32'h0);
		rd(`BUS_STATUS_OFS, 32'hc700, 32'h4100, "slv addr");
		apb(1'b1, `CMD_OFS, 32'h100);
		@(negedge clk);
		chk("slv cmd", {27'h0, cmd}, 32'h2);
		pulse('0, 5'h08);
		chk("slv dma rx", {31'h0, slv_dma_ok}, 32'h1);
		rd(`BUS_STATUS_OFS, 32'hc700, 32'h4300, "slv rx");
		pulse('0, 5'h04);
		chk("slv dma tx", {31'h0, slv_dma_ok}, 32'h1);
		rd(`BUS_STATUS_OFS, 32'hc700, 32'h4500, "slv tx");
		pulse('0, 5'h02);
		rd(`BUS_STATUS_OFS, 32'hc000, 32'h8000, "deselect");
		chk_irq(1'b0, "irq masked");
		apb(1'b1, `INT_EN_SET_OFS, 32'h8000);
		chk_irq(1'b1, "irq deselect");
		apb(1'b1, `BUS_STATUS_OFS, 32'h8000);
		chk_irq(1'b0, "irq cleared");
		rd(`BUS_STATUS_OFS, 32'hc000, 32'h0, "deselect clear");
		// Clock held low on an idle bus: only the clock time-out may rise.
		apb(1'b1, `LIMIT_OFS, 32'h2);
		apb(1'b1, `INT_EN_CLR_OFS, 32'h8000);
		apb(1'b1, `INT_EN_SET_OFS, 32'h0300_0000);
		stuck_low <= 1'b1;
		repeat (30) @(posedge clk);
		chk_irq(1'b0, "scl early");
		n = 0;
		while (irq !== 1'b1 && n < 40) begin
			@(negedge clk);
			n++;
		end
		chk_irq(1'b1, "scl timeout");
		stuck_low <= 1'b0;
		repeat (100) @(posedge clk);
		rd(`BUS_STATUS_OFS, 32'h0300_0000, 32'h0200_0000, "sticky");
		apb(1'b1, `BUS_STATUS_OFS, 32'h0);
		rd(`BUS_STATUS_OFS, 32'h0300_0000, 32'h0200_0000, "w0");
		apb(1'b1, `BUS_STATUS_OFS, 32'h0200_0000);
		rd(`BUS_STATUS_OFS, 32'h0300_0000, 32'h0, "w1");
		// A clocked frame, then a stall with the clock high mid-frame.
		frame <= 1'b1;
		repeat (10) @(posedge clk);
		clock_run <= 1'b1;
		repeat (400) @(posedge clk);
		rd(`BUS_STATUS_OFS, 32'h0300_0000, 32'h0, "clocking");
		clock_run <= 1'b0;
		repeat (100) @(posedge clk);
		rd(`BUS_STATUS_OFS, 32'h0300_0000, 32'h0100_0000, "stall");
		chk_irq(1'b1, "irq event");
		frame <= 1'b0;
		repeat (30) @(posedge clk);
		apb(1'b1, `BUS_STATUS_OFS, 32'h0100_0000);
		repeat (100) @(posedge clk);
		rd(`BUS_STATUS_OFS, 32'h0300_0000, 32'h0, "idle");
		give_verdict();
	end
endmodule

`default_nettype wire
